// ### pctim_chan.sv
// Purpose: one compare/capture channel of the wide timer
// Assumes: capture pin is asynchronous to clk
// Notes:   capture fires on a rising pin edge, three clocks after it
`timescale 1ns/1ps
`default_nettype none
module pctim_chan
    import pctim_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // configuration
    input  wire logic          en,
    input  wire logic          cap_mode,
    input  wire logic [WW-1:0] cmp,
    input  wire logic [WW-1:0] period,
    // wide counter
    input  wire logic [WW-1:0] count,
    input  wire logic          tick,
    // pin and results
    input  wire logic          cap_pin,
    output logic               pwm,
    output logic               cap_pulse
);
    logic sync1;
    logic sync2;
    logic prev;
    logic next_pwm;
    logic next_cap;

    // compare output follows the same wrap/match scheme as the narrow timers
    always_comb begin
        next_cap = cap_mode && sync2 && !prev;
        next_pwm = pwm;
        if (!en || cap_mode) begin
            next_pwm = 1'b0;
        end else if (tick) begin
            if (count == period) begin
                next_pwm = (cmp != 16'h0000);
            end else if ((count + 16'h0001) == cmp) begin
                next_pwm = 1'b0;
            end
        end
    end

    // sync1 feeds only sync2 to keep metastability away from the edge detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            prev      <= 1'b0;
            pwm       <= 1'b0;
            cap_pulse <= 1'b0;
        end else begin
            sync1     <= cap_pin;
            sync2     <= sync1;
            prev      <= sync2;
            pwm       <= next_pwm;
            cap_pulse <= next_cap;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cmatch;
        en && !cap_mode && tick && count != period && (count + 16'h0001) == cmp |=> !pwm;
    endproperty
    a_cmatch: assert property (p_cmatch) else $error("channel pwm not cleared at match");

    property p_cedge;
        cap_mode && $rose(sync2) |=> cap_pulse ##1 !cap_pulse;
    endproperty
    a_cedge: assert property (p_cedge) else $error("capture pulse missing");
endmodule : pctim_chan
`default_nettype wire

// ### pctim_narrow.sv
// Purpose: one 8-bit timer with prescaler, period and one pwm compare
// Assumes: configuration comes from registers on the same clock
// Notes:   idle output is low; it first rises at the first period end
`timescale 1ns/1ps
`default_nettype none
module pctim_narrow
    import pctim_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // configuration
    input  wire logic        en,
    input  wire pctim_ncfg_t cfg,
    // state and output
    output logic [NW-1:0]    count,
    output logic             pwm,
    output logic             wrap
);
    logic [NW-1:0] pre_cnt;
    logic [NW-1:0] next_pre_cnt;
    logic [NW-1:0] next_count;
    logic          next_pwm;
    logic          next_wrap;
    logic          tick;

    // prescaler, counter and pwm level
    always_comb begin
        tick         = en && (pre_cnt == cfg.presc);
        next_pre_cnt = (!en || tick) ? '0 : pre_cnt + 8'h01;
        next_count   = count;
        next_pwm     = pwm;
        next_wrap    = 1'b0;
        if (!en) begin
            next_count = '0;
            next_pwm   = 1'b0;
        end else if (tick) begin
            if (count == cfg.period) begin
                next_count = '0;
                next_pwm   = (cfg.cmp != 8'h00);
                next_wrap  = 1'b1;
            end else begin
                next_count = count + 8'h01;
                if ((count + 8'h01) == cfg.cmp) begin
                    next_pwm = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
            count   <= '0;
            pwm     <= 1'b0;
            wrap    <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            count   <= next_count;
            pwm     <= next_pwm;
            wrap    <= next_wrap;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_nwrap;
        tick && count == cfg.period |=> count == '0 && wrap;
    endproperty
    a_nwrap: assert property (p_nwrap) else $error("narrow counter missed wrap");

    property p_nmatch;
        tick && count != cfg.period && (count + 8'h01) == cfg.cmp |=> !pwm;
    endproperty
    a_nmatch: assert property (p_nmatch) else $error("narrow pwm not cleared at match");
endmodule : pctim_narrow
`default_nettype wire

// ### pctim_pkg.sv
// Purpose: shared constants and types for the general-purpose timer group
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register offsets are byte addresses
`default_nettype none
package pctim_pkg;
    localparam int NCH = 5;                        // wide timer channels
    localparam int NNT = 2;                        // narrow timers
    localparam int WW  = 16;                       // wide counter width
    localparam int NW  = 8;                        // narrow counter width

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WPRE   = 8'h04;
    localparam logic [7:0] OFS_WPER   = 8'h08;
    localparam logic [7:0] OFS_WCNT   = 8'h0c;
    localparam logic [7:0] OFS_CHMODE = 8'h10;
    localparam logic [7:0] OFS_STAT   = 8'h14;
    localparam logic [7:0] OFS_N0     = 8'h40;
    localparam logic [7:0] OFS_N1     = 8'h44;
    localparam logic [7:0] OFS_NCNT   = 8'h48;
    // channel value words sit at 8'h20 + 4*channel
    localparam logic [2:0] CHV_PAGE   = 3'h1;

    // control register bit positions
    localparam int CTRL_WEN  = 0;
    localparam int CTRL_IR   = 1;
    localparam int CTRL_N0EN = 2;
    localparam int CTRL_N1EN = 3;
    localparam int CTRL_W    = 4;
    // status: capture flags at bit 0 up, live wide pwm levels here
    localparam int STAT_PWM_LSB = 8;
    localparam int NCNT_N1_LSB  = 8;

    // ahb transfer type: bit 1 set means NONSEQ or SEQ
    localparam int HTRANS_ACT = 1;

    // narrow timer configuration word, high byte first
    typedef struct packed {
        logic [NW-1:0] presc;
        logic [NW-1:0] cmp;
        logic [NW-1:0] period;
    } pctim_ncfg_t;

    // latched address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } pctim_aph_t;

    localparam logic [WW-1:0]     WPER_RST  = 16'hffff;
    localparam logic [WW-1:0]     WPRE_RST  = 16'h0000;
    localparam logic [WW-1:0]     CHV_RST   = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
    localparam logic [NCH-1:0]    CHM_RST   = 5'h00;
    localparam pctim_ncfg_t       NCFG_RST  = '{presc: 8'h00, cmp: 8'h80, period: 8'hff};
    localparam pctim_aph_t        APH_IDLE  = '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
endpackage : pctim_pkg
`default_nettype wire

// ### pctim_top.sv
// Purpose: timer group: one 16-bit five-channel timer, two 8-bit timers
// Assumes: AHB-Lite slave with zero wait states, word accesses only
// Notes:   outputs are registered; narrow timer 0 drives infrared mode
`timescale 1ns/1ps
`default_nettype none
module pctim_top
    import pctim_pkg::*;
(
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // timer pins
    input  wire logic [NCH-1:0] cap_in,
    output logic [NCH-1:0]     wide_pwm,
    output logic [NNT-1:0]     narrow_pwm
);
    // registers
    logic [CTRL_W-1:0] ctrl;
    logic [WW-1:0]     wpre;
    logic [WW-1:0]     wper;
    logic [WW-1:0]     wcnt;
    logic [WW-1:0]     wpre_cnt;
    logic [NCH-1:0]    chmode;
    logic [NCH-1:0]    flags;
    logic [WW-1:0]     chval [NCH];
    pctim_ncfg_t       ncfg  [NNT];
    pctim_aph_t        aph;
    // next values
    logic [CTRL_W-1:0] next_ctrl;
    logic [WW-1:0]     next_wpre;
    logic [WW-1:0]     next_wper;
    logic [WW-1:0]     next_wcnt;
    logic [WW-1:0]     next_wpre_cnt;
    logic [NCH-1:0]    next_chmode;
    logic [NCH-1:0]    next_flags;
    logic [WW-1:0]     next_chval [NCH];
    pctim_ncfg_t       next_ncfg  [NNT];
    pctim_aph_t        next_aph;
    logic [31:0]       next_hrdata;
    logic [NCH-1:0]    next_wide_pwm;
    // internal nets
    logic              tick_w;
    logic [NCH-1:0]    ch_pwm;
    logic [NCH-1:0]    cap_pulse;
    logic [NW-1:0]     ncnt  [NNT];
    logic [NNT-1:0]    n_pwm;
    logic [NNT-1:0]    n_wrap;
    logic [NNT-1:0]    n_en;
    logic              wr_ctrl;
    logic              wr_wpre;
    logic              wr_wper;
    logic              wr_mode;
    logic              wr_stat;
    logic [NCH-1:0]    wr_chv;
    logic [NNT-1:0]    wr_ncfg;

    assign n_en = {ctrl[CTRL_N1EN], ctrl[CTRL_N0EN]};

    // narrow timers; timer 0 also serves as the infrared carrier
    for (genvar n = 0; n < NNT; n++) begin : g_narrow
        pctim_narrow u_narrow (
            .clk   (hclk),
            .rst_n (hresetn),
            .en    (n_en[n]),
            .cfg   (ncfg[n]),
            .count (ncnt[n]),
            .pwm   (n_pwm[n]),
            .wrap  (n_wrap[n])
        );
    end
    assign narrow_pwm = n_pwm;

    // wide channels
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        pctim_chan u_chan (
            .clk       (hclk),
            .rst_n     (hresetn),
            .en        (ctrl[CTRL_WEN]),
            .cap_mode  (chmode[c]),
            .cmp       (chval[c]),
            .period    (wper),
            .count     (wcnt),
            .tick      (tick_w),
            .cap_pin   (cap_in[c]),
            .pwm       (ch_pwm[c]),
            .cap_pulse (cap_pulse[c])
        );
    end

    // bus address phase is latched; writes land in the data phase
    always_comb begin
        next_aph = APH_IDLE;
        if (hsel && hready && htrans[HTRANS_ACT]) begin
            next_aph.wr   = hwrite;
            next_aph.rd   = !hwrite;
            next_aph.addr = haddr[7:0];
        end
        wr_ctrl = aph.wr && aph.addr == OFS_CTRL;
        wr_wpre = aph.wr && aph.addr == OFS_WPRE;
        wr_wper = aph.wr && aph.addr == OFS_WPER;
        wr_mode = aph.wr && aph.addr == OFS_CHMODE;
        wr_stat = aph.wr && aph.addr == OFS_STAT;
        wr_ncfg = {aph.wr && aph.addr == OFS_N1, aph.wr && aph.addr == OFS_N0};
    end

    for (genvar c = 0; c < NCH; c++) begin : g_wdec
        assign wr_chv[c] = aph.wr && aph.addr[7:5] == CHV_PAGE
                           && aph.addr[4:2] == 3'(c) && aph.addr[1:0] == 2'h0;
    end

    // read data is prepared from the address phase so hrdata comes from a flop;
    // a read placed right after a write to the same word sees the old value
    always_comb begin
        next_hrdata = '0;
        if (hsel && hready && htrans[HTRANS_ACT] && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL:   next_hrdata[CTRL_W-1:0] = ctrl;
                OFS_WPRE:   next_hrdata[WW-1:0]     = wpre;
                OFS_WPER:   next_hrdata[WW-1:0]     = wper;
                OFS_WCNT:   next_hrdata[WW-1:0]     = wcnt;
                OFS_CHMODE: next_hrdata[NCH-1:0]    = chmode;
                OFS_STAT: begin
                    next_hrdata[NCH-1:0] = flags;
                    next_hrdata[STAT_PWM_LSB +: NCH] = wide_pwm;
                end
                OFS_N0:     next_hrdata[$bits(pctim_ncfg_t)-1:0] = ncfg[0];
                OFS_N1:     next_hrdata[$bits(pctim_ncfg_t)-1:0] = ncfg[1];
                OFS_NCNT: begin
                    next_hrdata[NW-1:0] = ncnt[0];
                    next_hrdata[NCNT_N1_LSB +: NW] = ncnt[1];
                end
                default: begin
                    if (haddr[7:5] == CHV_PAGE && haddr[4:2] < 3'(NCH)
                        && haddr[1:0] == 2'h0) begin
                        next_hrdata[WW-1:0] = chval[haddr[4:2]];
                    end
                end
            endcase
        end
    end

    // configuration registers
    always_comb begin
        next_ctrl   = wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl;
        next_wpre   = wr_wpre ? hwdata[WW-1:0] : wpre;
        next_wper   = wr_wper ? hwdata[WW-1:0] : wper;
        next_chmode = wr_mode ? hwdata[NCH-1:0] : chmode;
        for (int n = 0; n < NNT; n++) begin
            next_ncfg[n] = wr_ncfg[n] ? pctim_ncfg_t'(hwdata[$bits(pctim_ncfg_t)-1:0])
                                      : ncfg[n];
        end
    end

    // channel values: a capture beats a software write in the same cycle;
    // flags clear by writing one, a new capture wins over that clear
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            next_chval[c] = chval[c];
            if (cap_pulse[c]) begin
                next_chval[c] = wcnt;
            end else if (wr_chv[c]) begin
                next_chval[c] = hwdata[WW-1:0];
            end
        end
        next_flags = (flags & ~(wr_stat ? hwdata[NCH-1:0] : '0)) | cap_pulse;
    end

    // wide counter: prescaled clocks, or carrier periods in infrared mode
    always_comb begin
        if (ctrl[CTRL_IR]) begin
            tick_w = ctrl[CTRL_WEN] && n_wrap[0];
        end else begin
            tick_w = ctrl[CTRL_WEN] && wpre_cnt == wpre;
        end
        next_wpre_cnt = (!ctrl[CTRL_WEN] || wpre_cnt == wpre) ? '0 : wpre_cnt + 16'h0001;
        next_wcnt     = wcnt;
        if (!ctrl[CTRL_WEN]) begin
            next_wcnt = '0;
        end else if (tick_w) begin
            next_wcnt = (wcnt == wper) ? '0 : wcnt + 16'h0001;
        end
        // gating the carrier here costs one clock of latency on every wide pwm pin
        next_wide_pwm = ch_pwm & ~chmode;
        if (ctrl[CTRL_IR]) begin
            next_wide_pwm = next_wide_pwm & {NCH{n_pwm[0]}};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph       <= APH_IDLE;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            ctrl      <= CTRL_RST;
            wpre      <= WPRE_RST;
            wper      <= WPER_RST;
            wcnt      <= '0;
            wpre_cnt  <= '0;
            chmode    <= CHM_RST;
            flags     <= '0;
            wide_pwm  <= '0;
            for (int c = 0; c < NCH; c++) chval[c] <= CHV_RST;
            for (int n = 0; n < NNT; n++) ncfg[n] <= NCFG_RST;
        end else begin
            aph       <= next_aph;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            ctrl      <= next_ctrl;
            wpre      <= next_wpre;
            wper      <= next_wper;
            wcnt      <= next_wcnt;
            wpre_cnt  <= next_wpre_cnt;
            chmode    <= next_chmode;
            flags     <= next_flags;
            wide_pwm  <= next_wide_pwm;
            for (int c = 0; c < NCH; c++) chval[c] <= next_chval[c];
            for (int n = 0; n < NNT; n++) ncfg[n] <= next_ncfg[n];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_wwrap;
        tick_w && wcnt == wper |=> wcnt == '0;
    endproperty
    a_wwrap: assert property (p_wwrap) else $error("wide counter missed wrap");

    property p_wstep;
        ctrl[CTRL_WEN] && !wr_ctrl && tick_w && wcnt != wper |=> wcnt == $past(wcnt) + 16'h0001;
    endproperty
    a_wstep: assert property (p_wstep) else $error("wide counter did not step");

    property p_whold;
        ctrl[CTRL_WEN] && !wr_ctrl && !tick_w |=> wcnt == $past(wcnt);
    endproperty
    a_whold: assert property (p_whold) else $error("wide counter moved without tick");

    property p_cmpw;
        wr_chv[0] && !cap_pulse[0] |=> chval[0] == $past(hwdata[WW-1:0]);
    endproperty
    a_cmpw: assert property (p_cmpw) else $error("compare value not stored");

    property p_capt;
        cap_pulse[1] |=> chval[1] == $past(wcnt) && flags[1];
    endproperty
    a_capt: assert property (p_capt) else $error("capture not stored or flagged");

    // the wide prescaler must be bypassed: no carrier wrap, no step
    property p_irtick;
        ctrl[CTRL_IR] && ctrl[CTRL_WEN] && !n_wrap[0] |=> wcnt == $past(wcnt);
    endproperty
    a_irtick: assert property (p_irtick) else $error("infrared tick not from carrier");

    property p_irand;
        ctrl[CTRL_IR] && !n_pwm[0] |=> wide_pwm == '0;
    endproperty
    a_irand: assert property (p_irand) else $error("infrared output not gated");

    property p_nout;
        n_en == '0 |=> narrow_pwm == '0;
    endproperty
    a_nout: assert property (p_nout) else $error("narrow pwm pin not driven");

    c_irwrap: cover property (ctrl[CTRL_IR] && tick_w && wcnt == wper);
    c_capture: cover property (cap_pulse[0] ##1 flags[0]);
    c_pwmhigh: cover property (!ctrl[CTRL_IR] && $rose(wide_pwm[2]));
    c_read: cover property (aph.rd && aph.addr == OFS_WCNT);
endmodule : pctim_top
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for the timer group behind its register bus
// Assumes: zero wait state slave, hready looped back from hreadyout
// Notes:   pwm is judged by high-cycle counts over whole periods, so a
//          one-clock output latency cannot change the result
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pctim_pkg::*;
;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    wire logic        hready;
    logic             hreadyout;
    logic             hresp;
    logic [31:0]      hrdata;
    logic [NCH-1:0]   cap_in;
    logic [NCH-1:0]   wide_pwm;
    logic [NNT-1:0]   narrow_pwm;
    logic             pend;
    logic [31:0]      expq[$];
    logic [31:0]      v;
    logic [15:0]      chv[NCH];
    logic [4:0]       mask;
    int               mismatches;
    int               n_tests;
    int               cw[NCH];
    int               cn[NNT];

    assign hready = hreadyout;

    pctim_top DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cap_in(cap_in), .wide_pwm(wide_pwm), .narrow_pwm(narrow_pwm)
    );

    always #2 hclk = ~hclk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for the edge that ends the current bus phase
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                mismatches++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        xfer(1'b0, a, 32'h00000000);
    endtask : rd

    function automatic logic [7:0] chv_addr(input int i);
        return 8'h20 + 8'(4 * i);
    endfunction : chv_addr

    // count high cycles of every pwm pin over n clocks
    task automatic measure(input int n);
        for (int i = 0; i < NCH; i++) cw[i] = 0;
        for (int i = 0; i < NNT; i++) cn[i] = 0;
        repeat (n) begin
            @(negedge hclk);
            for (int i = 0; i < NCH; i++) cw[i] += int'(wide_pwm[i] === 1'b1);
            for (int i = 0; i < NNT; i++) cn[i] += int'(narrow_pwm[i] === 1'b1);
        end
    endtask : measure

    // read-data watcher: the data phase follows an accepted read address phase
    initial pend = 1'b0;
    always @(posedge hclk) begin
        if (pend && hreadyout === 1'b1) begin
            if (expq.size() == 0) begin
                check(hrdata, 32'hdeadbeef);
            end else begin
                check(hrdata, expq.pop_front());
            end
            check({31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1)
            pend <= hsel && htrans[1] && !hwrite && hresetn;
    end

    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = '0; cap_in = '0; mask = '0;
        mismatches = 0;
        n_tests = 0;
        v = $urandom(2123);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, read-only count and an unmapped word
        rd(OFS_CTRL, 0); rd(OFS_WPRE, 0); rd(OFS_WPER, 32'hffff);
        rd(OFS_CHMODE, 0); rd(OFS_STAT, 0); rd(OFS_WCNT, 0);
        for (int i = 0; i < NCH; i++) rd(chv_addr(i), 0);
        rd(OFS_N0, 32'h0080ff); rd(OFS_N1, 32'h0080ff); rd(OFS_NCNT, 0);
        wr(8'h80, $urandom); rd(8'h80, 0);
        // random compare words; upper half is reserved
        for (int i = 0; i < NCH; i++) begin
            v = $urandom;
            chv[i] = v[15:0] | 16'h0001;
            wr(chv_addr(i), {v[31:16], chv[i]});
            rd(chv_addr(i), {16'h0, chv[i]});
        end
        v = $urandom;
        wr(OFS_N1, v); rd(OFS_N1, {8'h00, v[23:0]});
        // period 3: compare i gives i of 4 counts high, 4 and up always high
        wr(OFS_WPER, 3);
        for (int i = 0; i < NCH; i++) wr(chv_addr(i), i);
        for (int pre = 0; pre < 2; pre++) begin
            wr(OFS_CTRL, 0); wr(OFS_WPRE, pre); wr(OFS_CTRL, 1);
            repeat (20) @(posedge hclk);
            measure(40 * (pre + 1));
            for (int i = 0; i < NCH; i++) check(cw[i], i * 10 * (pre + 1));
        end
        // capture with the count parked at 0 by a huge prescale
        wr(OFS_CTRL, 0); wr(OFS_WPRE, 32'hffff); wr(OFS_CHMODE, 32'h1f);
        for (int i = 0; i < NCH; i++) wr(chv_addr(i), chv[i]);
        wr(OFS_CTRL, 1);
        for (int i = 0; i < NCH; i++) begin
            cap_in[i] <= 1'b1;
            repeat (8) @(posedge hclk);
            cap_in[i] <= 1'b0;
            mask[i] = 1'b1;
            rd(OFS_STAT, mask);
            rd(chv_addr(i), 0);
            if (i == 0) rd(chv_addr(NCH - 1), chv[NCH - 1]);
        end
        measure(20);
        for (int i = 0; i < NCH; i++) check(cw[i], 0);
        wr(OFS_STAT, 32'h1f); rd(OFS_STAT, 0);
        // infrared mode: prescaler set on purpose to show it is bypassed
        wr(OFS_CTRL, 0); wr(OFS_CHMODE, 0); wr(OFS_WPRE, 5);
        for (int i = 0; i < NCH; i++) wr(chv_addr(i), i);
        wr(OFS_N0, 32'h000204); wr(OFS_N1, 32'h010307);
        wr(OFS_CTRL, 32'hf);
        repeat (200) @(posedge hclk);
        measure(80);
        check(cn[0], 32);
        check(cn[1], 30);
        for (int i = 0; i < NCH; i++) check(cw[i], 8 * i);
        // disabled timers hold count 0 and outputs low
        wr(OFS_CTRL, 0);
        rd(OFS_NCNT, 0); rd(OFS_WCNT, 0);
        measure(20);
        check(cn[0] + cn[1], 0);
        repeat (5) @(posedge hclk);
        check(expq.size(), 0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
